// file: rtl/smps_mem.sv
// single-port memory with registered read data
module smps_mem #(
    parameter int AW = 8,
    parameter int W  = 8
) (
    input  wire logic         clk,
    input  wire logic         we,
    input  wire logic         re,
    input  wire logic [AW-1:0] addr,
    input  wire logic [W-1:0] wdata,
    output logic      [W-1:0] rdata
);
    logic [W-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk)
    begin
        if (we)
            mem[addr] <= wdata;
        if (re)
            rdata <= mem[addr];
    end
endmodule : smps_mem

// file: rtl/smps_pkg.sv
// constants, register map and types of the self-program memory sequencer
package smps_pkg;
    localparam int          DW          = 8;
    localparam int          FLASH_AW    = 16;
    localparam int          FLASH_DW    = 14;
    localparam int          EE_AW       = 8;
    localparam int          ROW_LSB     = 5;
    localparam int          ROW_WORDS   = 32;
    localparam logic [5:0]  OFF_ADDR_LO = 6'h00;
    localparam logic [5:0]  OFF_ADDR_HI = 6'h04;
    localparam logic [5:0]  OFF_DATA_LO = 6'h08;
    localparam logic [5:0]  OFF_DATA_HI = 6'h0C;
    localparam logic [5:0]  OFF_CTRL    = 6'h10;
    localparam logic [5:0]  OFF_UNLOCK  = 6'h14;
    localparam logic [5:0]  OFF_STATUS  = 6'h18;
    localparam logic [5:0]  OFF_MASK    = 6'h1C;
    localparam int          B_PSS       = 7;
    localparam int          B_FREE      = 4;
    localparam int          B_WRITE_ENABLE_LATCH      = 2;
    localparam int          B_WR        = 1;
    localparam int          B_RD        = 0;
    localparam int          S_EE_DONE   = 0;
    localparam int          S_ER_DONE   = 1;
    localparam logic [7:0]  UNLOCK_1    = 8'h55;
    localparam logic [7:0]  UNLOCK_2    = 8'hAA;
    localparam logic [13:0] ERASED_WORD = 14'h3FFF;
    localparam int          CLK_MHZ     = 125;
    localparam int          ERASE_US    = 2000;
    localparam int          ERASE_CYC   = ERASE_US * CLK_MHZ;
    localparam int          EE_WR_CYC   = 4000;
    localparam int          SETUP_CYC   = 2;
    localparam int          CNT_W       = 20;
    typedef enum logic [1:0] {UL_NONE, UL_ONE, UL_TWO} smps_ul_t;
    typedef enum logic [2:0] {
        ST_IDLE, ST_RD_WAIT, ST_RD_SLOT, ST_EE_RD, ST_ER_SETUP, ST_ER_RUN, ST_EE_RUN
    } smps_st_t;
endpackage : smps_pkg

// file: rtl/smps_seq.sv
// self-program memory sequencer: wishbone registers, unlock, read slot, row erase
// Notes on behaviour
// R1: software loads both address bytes, sets program select, then read strobe.
// R2: program read uses the second cycle after the strobe; that instruction is squashed.
// R3: fetched word sits in data low and high right after the access.
// R4: data registers hold until another read or a software write.
// R5: self erase works on one 32-word row; no single-word erase.
// R6: no bulk erase beyond one row from the self sequence.
// R7: row picked by address bits 15:5; bits 4:0 ignored.
// R8: erase starts only with program select, write enable and erase select set.
// R9: software writes 55h then AAh to the unlock register before the strobe.
// R10: two setup cycles follow the write strobe before the halt.
// R11: processor halted for about 2 ms during erase; clocks keep running.
// R12: halt releases so execution resumes at the third instruction.
// R13: software masks interrupts around unlock and clears bits after erase.
// R14: no write or erase without the exact 55h, AAh, strobe order.
// R15: strobe blocked while write enable clear; later clearing does not stop it.
// R16: data write completion clears strobe and sets the done flag.
// R17: with program select clear, read strobe loads data byte at low address.
//
// Local design decisions: the placing of the registers and the Wishbone slave port.
module smps_seq
    import smps_pkg::*;
#(
    parameter int ERASE_CYCLES = smps_pkg::ERASE_CYC,
    parameter int EE_WR_CYCLES = smps_pkg::EE_WR_CYC
) (
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [5:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             irq,
    output logic             cpu_squash,
    output logic             cpu_halt
);
    import smps_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    logic              ack_q;
    logic [31:0]       dat_q;
    logic [7:0]        addr_lo_q;
    logic [7:0]        addr_hi_q;
    logic [7:0]        data_lo_q;
    logic [5:0]        data_hi_q;
    logic              pss_q;
    logic              free_q;
    logic              write_enable_latch_q;
    logic              wr_q;
    logic [1:0]        stat_q;
    logic [1:0]        mask_q;
    smps_ul_t          ul_q;
    smps_st_t          st_q;
    logic [CNT_W-1:0]  cnt_q;
    logic [10:0]       row_q;
    logic              wr_acc;
    logic              rd_acc;
    logic              ctl_wr;
    logic              go_wr;
    logic              go_er;
    logic              go_ee;
    logic              go_rd;
    logic              go_prd;
    logic              go_erd;
    logic              fl_we;
    logic              fl_re;
    logic [15:0]       fl_addr;
    logic [13:0]       fl_rdata;
    logic              ee_we;
    logic [7:0]        ee_rdata;
    logic [7:0]        rd_mux;

    function automatic logic hit(input logic [5:0] a, input logic [5:0] off);
        hit = (a == off);
    endfunction : hit

    ////////////////////////////////////////////////////////////////////////////
    // bus slave: one wait state, effects land on the ack edge
    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign wr_acc   = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && wb_sel_i[0];
    assign rd_acc   = wb_cyc_i && wb_stb_i && !wb_we_i && ack_q;
    assign ctl_wr   = wr_acc && hit(wb_adr_i, OFF_CTRL);

    always_comb
    begin
        rd_mux = 8'h00;
        case (wb_adr_i)
            OFF_ADDR_LO: rd_mux = addr_lo_q;
            OFF_ADDR_HI: rd_mux = addr_hi_q;
            OFF_DATA_LO: rd_mux = data_lo_q;
            OFF_DATA_HI: rd_mux = {2'h0, data_hi_q};
            OFF_CTRL:    rd_mux = {pss_q, 2'h0, free_q, 1'b0, write_enable_latch_q, wr_q,
                                   (st_q == ST_RD_WAIT) || (st_q == ST_RD_SLOT)};
            OFF_STATUS:  rd_mux = {6'h00, stat_q};
            OFF_MASK:    rd_mux = {6'h00, mask_q};
            default:     rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end
        else
        begin
            ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
            if (wb_cyc_i && wb_stb_i && !ack_q)
                dat_q <= {24'h00_0000, rd_mux};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // start decode; the strobe only counts after a fresh unlock pair
    assign go_wr  = ctl_wr && wb_dat_i[B_WR] && wb_dat_i[B_WRITE_ENABLE_LATCH]                // see R15
                    && (ul_q == UL_TWO) && (st_q == ST_IDLE);                   // see R14
    // program-space write without erase select belongs to block writes, not here
    assign go_er  = go_wr && wb_dat_i[B_PSS] && wb_dat_i[B_FREE];               // see R8
    assign go_ee  = go_wr && !wb_dat_i[B_PSS];
    assign go_rd  = ctl_wr && wb_dat_i[B_RD] && !go_wr && (st_q == ST_IDLE);
    assign go_prd = go_rd && wb_dat_i[B_PSS];
    assign go_erd = go_rd && !wb_dat_i[B_PSS];

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            ul_q <= UL_NONE;
        else if (wr_acc)
        begin
            if (hit(wb_adr_i, OFF_UNLOCK) && wb_dat_i[7:0] == UNLOCK_1)
                ul_q <= UL_ONE;
            else if (hit(wb_adr_i, OFF_UNLOCK) && wb_dat_i[7:0] == UNLOCK_2
                     && ul_q == UL_ONE)
                ul_q <= UL_TWO;
            else
                ul_q <= UL_NONE;                                                // see R14
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // software registers
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            addr_lo_q <= 8'h00;
            addr_hi_q <= 8'h00;
            pss_q     <= 1'b0;
            free_q    <= 1'b0;
            write_enable_latch_q    <= 1'b0;
            mask_q    <= 2'h0;
        end
        else if (wr_acc)
        begin
            if (hit(wb_adr_i, OFF_ADDR_LO))
                addr_lo_q <= wb_dat_i[7:0];
            if (hit(wb_adr_i, OFF_ADDR_HI))
                addr_hi_q <= wb_dat_i[7:0];
            if (hit(wb_adr_i, OFF_MASK))
                mask_q <= wb_dat_i[1:0];
            // clearing the latch mid-operation is harmless: wr_q carries it
            if (hit(wb_adr_i, OFF_CTRL))
            begin
                pss_q  <= wb_dat_i[B_PSS];
                free_q <= wb_dat_i[B_FREE];
                write_enable_latch_q <= wb_dat_i[B_WRITE_ENABLE_LATCH];                                     // see R15
            end
        end
    end

    // data registers change only by a read or a software write
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            data_lo_q <= 8'h00;
            data_hi_q <= 6'h00;
        end
        else if (st_q == ST_RD_SLOT)
        begin
            data_lo_q <= fl_rdata[7:0];                                         // see R3
            data_hi_q <= fl_rdata[13:8];
        end
        else if (st_q == ST_EE_RD)
            data_lo_q <= ee_rdata;                                              // see R17
        else if (wr_acc && hit(wb_adr_i, OFF_DATA_LO))
            data_lo_q <= wb_dat_i[7:0];                                         // see R4
        else if (wr_acc && hit(wb_adr_i, OFF_DATA_HI))
            data_hi_q <= wb_dat_i[5:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_q  <= ST_IDLE;
            cnt_q <= '0;
            row_q <= 11'h000;
            wr_q  <= 1'b0;
        end
        else
        begin
            case (st_q)
                ST_IDLE:
                begin
                    cnt_q <= '0;
                    if (go_er)
                    begin
                        st_q  <= ST_ER_SETUP;
                        wr_q  <= 1'b1;
                        row_q <= {addr_hi_q, addr_lo_q[7:ROW_LSB]};             // see R7
                    end
                    else if (go_ee)
                    begin
                        st_q <= ST_EE_RUN;
                        wr_q <= 1'b1;
                    end
                    else if (go_prd)
                        st_q <= ST_RD_WAIT;
                    else if (go_erd)
                        st_q <= ST_EE_RD;
                end
                ST_RD_WAIT:
                    st_q <= ST_RD_SLOT;                                         // see R2
                ST_RD_SLOT:
                    st_q <= ST_IDLE;
                ST_EE_RD:
                    st_q <= ST_IDLE;
                ST_ER_SETUP:
                begin
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q == CNT_W'(SETUP_CYC - 1))                         // see R10
                    begin
                        st_q  <= ST_ER_RUN;
                        cnt_q <= '0;
                    end
                end
                ST_ER_RUN:
                begin
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q == CNT_W'(ERASE_CYCLES - 1))                      // see R11
                    begin
                        st_q <= ST_IDLE;                                        // see R12
                        wr_q <= 1'b0;
                    end
                end
                ST_EE_RUN:
                begin
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q == CNT_W'(EE_WR_CYCLES - 1))
                    begin
                        st_q <= ST_IDLE;
                        wr_q <= 1'b0;                                           // see R16
                    end
                end
                default:
                    st_q <= ST_IDLE;
            endcase
        end
    end

    assign cpu_squash = (st_q == ST_RD_SLOT);                                   // see R2
    assign cpu_halt   = (st_q == ST_ER_RUN);                                    // see R11

    ////////////////////////////////////////////////////////////////////////////
    // status: read clears, a same-cycle event wins over the clear
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            stat_q <= 2'h0;
        else
        begin
            if (rd_acc && hit(wb_adr_i, OFF_STATUS))
                stat_q <= 2'h0;
            if (st_q == ST_EE_RUN && cnt_q == CNT_W'(EE_WR_CYCLES - 1))
                stat_q[S_EE_DONE] <= 1'b1;                                      // see R16
            if (st_q == ST_ER_RUN && cnt_q == CNT_W'(ERASE_CYCLES - 1))
                stat_q[S_ER_DONE] <= 1'b1;
        end
    end

    assign irq = |(stat_q & mask_q);

    ////////////////////////////////////////////////////////////////////////////
    // memories; erase walks only the 32 words of the latched row
    assign fl_we   = (st_q == ST_ER_RUN) && (cnt_q < CNT_W'(ROW_WORDS));        // see R5
    assign fl_re   = (st_q == ST_RD_WAIT);
    assign fl_addr = fl_we ? {row_q, cnt_q[ROW_LSB-1:0]}                        // see R6
                           : {addr_hi_q, addr_lo_q};
    assign ee_we   = go_ee;

    smps_mem #(.AW(FLASH_AW), .W(FLASH_DW)) u_flash (
        .clk   (sys_clk),
        .we    (fl_we),
        .re    (fl_re),
        .addr  (fl_addr),
        .wdata (ERASED_WORD),
        .rdata (fl_rdata)
    );

    smps_mem #(.AW(EE_AW), .W(DW)) u_ee (
        .clk   (sys_clk),
        .we    (ee_we),
        .re    (go_erd),
        .addr  (addr_lo_q),
        .wdata (data_lo_q),
        .rdata (ee_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    // checks
    logic [CNT_W-1:0] halt_len_q;

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            halt_len_q <= '0;
        else if (cpu_halt)
            halt_len_q <= halt_len_q + 1'b1;
        else
            halt_len_q <= '0;
    end

    property p_rd_squash;
        @(posedge sys_clk) disable iff (!resetn)
        go_prd |-> !cpu_squash ##1 !cpu_squash ##1 cpu_squash ##1 !cpu_squash;
    endproperty
    a_rd_squash: assert property (p_rd_squash) else $error("squash slot wrong"); // see R2

    property p_rd_data;
        @(posedge sys_clk) disable iff (!resetn)
        cpu_squash |=> data_lo_q == $past(fl_rdata[7:0])
                       && data_hi_q == $past(fl_rdata[13:8]);
    endproperty
    a_rd_data: assert property (p_rd_data) else $error("word not loaded"); // see R3

    property p_data_hold;
        @(posedge sys_clk) disable iff (!resetn)
        (st_q == ST_IDLE && !wr_acc) |=> $stable(data_lo_q) && $stable(data_hi_q);
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("data changed"); // see R4

    property p_row;
        @(posedge sys_clk) disable iff (!resetn)
        fl_we |-> fl_addr[15:ROW_LSB] == {addr_hi_q, addr_lo_q[7:ROW_LSB]}
                  && fl_addr[ROW_LSB-1:0] == cnt_q[ROW_LSB-1:0];
    endproperty
    a_row: assert property (p_row) else $error("erase left its row"); // see R7

    property p_er_gate;
        @(posedge sys_clk) disable iff (!resetn)
        $rose(wr_q) && st_q == ST_ER_SETUP |-> pss_q && write_enable_latch_q && free_q;
    endproperty
    a_er_gate: assert property (p_er_gate) else $error("erase without bits"); // see R8

    property p_unlock;
        @(posedge sys_clk) disable iff (!resetn)
        $rose(wr_q) |-> $past(ul_q) == UL_TWO && ul_q == UL_NONE;
    endproperty
    a_unlock: assert property (p_unlock) else $error("start without unlock"); // see R14

    property p_write_enable_latch_block;
        @(posedge sys_clk) disable iff (!resetn)
        (ctl_wr && !wb_dat_i[B_WRITE_ENABLE_LATCH] && !wr_q) |=> !wr_q;
    endproperty
    a_write_enable_latch_block: assert property (p_write_enable_latch_block) else $error("strobe without latch"); // see R15

    property p_setup;
        @(posedge sys_clk) disable iff (!resetn)
        go_er |=> !cpu_halt ##1 !cpu_halt ##1 cpu_halt;
    endproperty
    a_setup: assert property (p_setup) else $error("setup not two cycles"); // see R10

    property p_halt_len;
        @(posedge sys_clk) disable iff (!resetn)
        $fell(cpu_halt) |-> $past(halt_len_q) == CNT_W'(ERASE_CYCLES - 1) && !wr_q;
    endproperty
    a_halt_len: assert property (p_halt_len) else $error("halt length wrong"); // see R11

    property p_ee_done;
        @(posedge sys_clk) disable iff (!resetn)
        $fell(wr_q) && $past(st_q) == ST_EE_RUN |-> stat_q[S_EE_DONE];
    endproperty
    a_ee_done: assert property (p_ee_done) else $error("done flag missing"); // see R16

    property p_ee_read;
        @(posedge sys_clk) disable iff (!resetn)
        go_erd |-> ##2 data_lo_q == $past(ee_rdata);
    endproperty
    a_ee_read: assert property (p_ee_read) else $error("data byte not read"); // see R17

    c_prog_read: cover property (@(posedge sys_clk) disable iff (!resetn) cpu_squash);
    c_erase:     cover property (@(posedge sys_clk) disable iff (!resetn) $fell(cpu_halt));
    c_ee_write:  cover property (@(posedge sys_clk) disable iff (!resetn)
                                 $fell(wr_q) && stat_q[S_EE_DONE]);
    c_irq:       cover property (@(posedge sys_clk) disable iff (!resetn) $rose(irq));
endmodule : smps_seq

// file: testbench/self_program_memory_sequencer_test.sv
// self-checking bench: register tasks over wishbone, read, data write, row erase
module self_program_memory_sequencer_test;
    timeunit 1ns;
    timeprecision 1ps;
    import smps_pkg::*;

    localparam int N_ER = 64;
    localparam int N_EW = 8;
    logic        sys_clk;
    logic        resetn;
    logic        wb_cyc_i;
    logic        wb_stb_i;
    logic        wb_we_i;
    logic [5:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        irq;
    logic        cpu_squash;
    logic        cpu_halt;
    logic [15:0] halt_n;
    logic [15:0] squash_n;
    logic [15:0] retired_n;
    logic [15:0] r0;
    logic [31:0] v;
    int          fails;
    int          n_tests;
    int          k;
    int          j;

    smps_seq #(.ERASE_CYCLES(N_ER), .EE_WR_CYCLES(N_EW)) DUT (
        .sys_clk(sys_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq), .cpu_squash(cpu_squash),
        .cpu_halt(cpu_halt));
    smps_cpu_model cpu (
        .sys_clk(sys_clk), .resetn(resetn), .cpu_halt(cpu_halt), .cpu_squash(cpu_squash),
        .halt_n(halt_n), .squash_n(squash_n), .retired_n(retired_n));

    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        if (fails == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // request held from launch edge to the edge that samples ack high
    task automatic xfer(input logic we, input logic [5:0] a, input logic [7:0] d,
                        input logic [3:0] sel, output logic [31:0] rd_v);
        int n;
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_sel_i <= sel;
        wb_dat_i <= {24'h000000, d};
        for (n = 0; n < 20; n++)
        begin
            @(posedge sys_clk);
            if (wb_ack_o === 1'b1)
                break;
        end
        if (n == 20)
        begin
            fails++;
            report_and_stop();
        end
        rd_v = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [31:0] x;
        xfer(1'b1, a, d, 4'hF, x);
    endtask : wr

    task automatic rd(input logic [5:0] a, output logic [31:0] d);
        xfer(1'b0, a, 8'h00, 4'hF, d);
    endtask : rd

    task automatic unlock();
        wr(OFF_UNLOCK, UNLOCK_1);
        wr(OFF_UNLOCK, UNLOCK_2);
    endtask : unlock

    // edges after the launching write until halt (sel=1) or squash (sel=0) is seen
    task automatic edges_to(input bit sel, output int n);
        for (n = 1; n < 12; n++)
        begin
            @(posedge sys_clk);
            if ((sel ? cpu_halt : cpu_squash) === 1'b1)
                break;
        end
        if (n == 12)
        begin
            fails++;
            report_and_stop();
        end
    endtask : edges_to

    task automatic wait_idle();
        int n;
        logic [31:0] c;
        for (n = 0; n < 60; n++)
        begin
            rd(OFF_CTRL, c);
            if (c[B_WR] === 1'b0)
                break;
        end
        if (n == 60)
        begin
            fails++;
            report_and_stop();
        end
    endtask : wait_idle

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {wb_cyc_i, wb_stb_i, wb_we_i} = 3'b000;
        wb_adr_i = 6'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h00000000;
        resetn   = 1'b0;
        fails    = 0;
        n_tests  = 0;
        repeat (5) @(posedge sys_clk);
        resetn <= 1'b1;
        for (k = 0; k <= 8; k++)
        begin
            rd(6'(k * 4), v);
            check("reset_value", v, 32'h00000000);
        end
        // data high keeps 6 bits; masked byte lane and unmapped writes are dropped
        wr(OFF_DATA_HI, 8'hFF);
        rd(OFF_DATA_HI, v);
        check("data_high_width", v, 32'h0000003F);
        xfer(1'b1, OFF_ADDR_LO, 8'h99, 4'hE, v);
        rd(OFF_ADDR_LO, v);
        check("addr_low_sel", v, 32'h00000000);
        wr(6'h20, 8'h5C);
        rd(6'h20, v);
        check("unmapped", v, 32'h00000000);
        // data byte write; dropping write enable mid-write must not abort it
        wr(OFF_ADDR_LO, 8'h12);
        wr(OFF_DATA_LO, 8'h5A);
        unlock();
        wr(OFF_CTRL, 8'h06);
        wr(OFF_CTRL, 8'h00);
        rd(OFF_CTRL, v);
        check("ee_busy", v & 32'h2, 32'h00000002);
        wait_idle();
        @(negedge sys_clk);
        check("irq_masked", irq, 1'b0);
        wr(OFF_MASK, 8'h03);
        @(negedge sys_clk);
        check("irq_on", irq, 1'b1);
        rd(OFF_STATUS, v);
        check("ee_done", v, 32'h00000001);
        @(negedge sys_clk);
        check("irq_off", irq, 1'b0);
        // refused strobes: no unlock, broken unlock, write enable clear
        for (k = 0; k < 3; k++)
        begin
            wr(OFF_DATA_LO, 8'h77);
            if (k > 0)
                wr(OFF_UNLOCK, UNLOCK_1);
            if (k == 1)
                wr(OFF_ADDR_LO, 8'h12);
            if (k > 0)
                wr(OFF_UNLOCK, UNLOCK_2);
            wr(OFF_CTRL, (k == 2) ? 8'h02 : 8'h06);
            rd(OFF_CTRL, v);
            check("ctrl_refused", v, (k == 2) ? 32'h0 : 32'h4);
        end
        wr(OFF_CTRL, 8'h01);
        repeat (2) @(posedge sys_clk);
        rd(OFF_DATA_LO, v);
        check("ee_readback", v, 32'h0000005A);
        rd(OFF_STATUS, v);
        check("no_done", v, 32'h00000000);
        // program write without erase select must not halt
        unlock();
        wr(OFF_CTRL, 8'h86);
        repeat (8) @(posedge sys_clk);
        check("no_erase", halt_n, 16'h0000);
        // row erase, low address bits set to show they are ignored
        wr(OFF_ADDR_HI, 8'h01);
        wr(OFF_ADDR_LO, 8'h3F);
        unlock();
        wr(OFF_CTRL, 8'h96);
        r0 = retired_n;
        edges_to(1'b1, k);
        check("erase_setup", k, 3);
        for (k = 0; k < 200 && cpu_halt === 1'b1; k++)
            @(posedge sys_clk);
        if (k == 200)
        begin
            fails++;
            report_and_stop();
        end
        check("halt_len", halt_n, 16'(N_ER));
        check("resume_point", retired_n - r0, 16'(SETUP_CYC + 1));
        rd(OFF_CTRL, v);
        check("erase_wr_clr", v, 32'h00000094);
        rd(OFF_STATUS, v);
        check("erase_done", v, 32'h00000002);
        // program reads at both ends of the erased row
        for (j = 0; j < 2; j++)
        begin
            wr(OFF_ADDR_LO, j ? 8'h3F : 8'h20);
            wr(OFF_CTRL, 8'h81);
            edges_to(1'b0, k);
            check("read_slot", k, 2);
            @(posedge sys_clk);
            rd(OFF_DATA_LO, v);
            check("word_low", v, 32'h000000FF);
            rd(OFF_DATA_HI, v);
            check("word_high", v, 32'h0000003F);
        end
        check("squash_count", squash_n, 16'h0002);
        report_and_stop();
    end
endmodule : self_program_memory_sequencer_test

// file: testbench/smps_cpu_model.sv
// processor-side model: retires one instruction a cycle unless halted or squashed
module smps_cpu_model (
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic        cpu_halt,
    input  wire logic        cpu_squash,
    output logic      [15:0] halt_n,
    output logic      [15:0] squash_n,
    output logic      [15:0] retired_n
);
    timeunit 1ns;
    timeprecision 1ps;

    // counters only clear on reset, so the bench compares a delta of retired_n; halt_n and squash_n are checked as totals
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            halt_n    <= 16'h0000;
            squash_n  <= 16'h0000;
            retired_n <= 16'h0000;
        end
        else if (cpu_halt)
            halt_n <= halt_n + 16'h0001;
        else if (cpu_squash)
            squash_n <= squash_n + 16'h0001;
        else
            retired_n <= retired_n + 16'h0001;
    end
endmodule : smps_cpu_model
